/* ssp_map.svh */
// Constants for the serial position slave: frame layout and timing.
// Assumes a 40 MHz core clock; included by the package and the design.
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_CLK_MHZ 40
`define SSP_TOUT_NS 7000
`define SSP_TOUT_CYC ((`SSP_TOUT_NS * `SSP_CLK_MHZ) / 1000)
`define SSP_START_MIN 8
`define SSP_START_MAX 64
`define SSP_START_DEF 7'h08
`define SSP_TURN_W 16
`define SSP_ANGLE_W 17
`define SSP_SHIFT_W 35
`define SSP_VAR_MULTI 2'h0
`define SSP_VAR_SINGLE 2'h1
`define SSP_VAR_EXT 2'h2
`endif

/* ssp_pkg.sv */
// Types for the serial position slave.
// Assumes ssp_map.svh is on the include path.
`include "ssp_map.svh"
package ssp_pkg;
  typedef struct packed {
    logic [`SSP_TURN_W-1:0] turns;
    logic [`SSP_ANGLE_W-1:0] angle;
    logic healthy;
  } ssp_pos_t;
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_ARMED = 2'b01,
    SSP_START = 2'b10,
    SSP_DATA = 2'b11
  } ssp_state_t;
endpackage

/* ssp_slave.sv */
// Synchronous serial position slave: clock in from the master, data out.
// Assumes the position source is on clk; the master clock is asynchronous.
//
// Contract
// - Position is captured on the first falling master clock edge.
// - Data goes low on first rising edge and stays low for start phase.
// - Start phase length is 8 to 64 bits, default 8.
// - Multiturn: 16-bit turn count then 17-bit angle, MSB first.
// - Single-turn: only the 17-bit angle, MSB first.
// - Extended: a zero bit then a status bit follow the angle.
// - Status bit is one when healthy, zero on internal error.
// - Clock idle beyond the timeout aborts and ends the frame.
// - End of frame recognised within 7 us of idle clock.
// - Frames are framed only by master clock; device never drives it.
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_slave (
  input wire logic clk,
  input wire logic resetn,
  input wire logic master_clock_line,
  input wire ssp_pkg::ssp_pos_t position,
  input wire logic [6:0] start_bits,
  input wire logic [1:0] variant,
  output logic data_out
);
  // Timeout in core cycles; the synchroniser lag is taken off so that the
  // end of a frame is seen within the idle limit measured at the pin
  localparam logic [8:0] TOUT_CYC = 9'(`SSP_TOUT_CYC);
  localparam logic [8:0] SYNC_LAG = 9'h004;
  localparam logic [8:0] TOUT_END = TOUT_CYC - SYNC_LAG;

  // Synchroniser stages for the master clock
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  // Synchroniser stages for the configuration pins
  logic [6:0] start_s1_q;
  logic [6:0] start_s2_q;
  logic [1:0] var_s1_q;
  logic [1:0] var_s2_q;
  // Frame sequencer
  ssp_pkg::ssp_state_t state_q;
  ssp_pkg::ssp_state_t state_d;
  // Idle timer
  logic [8:0] idle_q;
  logic [8:0] idle_d;
  // Start-phase and data bit counters
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [5:0] bits_q;
  logic [5:0] bits_d;
  // Transmit shift path and data line
  logic [`SSP_SHIFT_W-1:0] shift_q;
  logic [`SSP_SHIFT_W-1:0] shift_d;
  logic data_q;
  logic data_d;

  // Master clock edges; only the second and third stages are read here
  wire fall = clk_s3_q & ~clk_s2_q;
  wire rise = ~clk_s3_q & clk_s2_q;
  wire timeout = (idle_q == TOUT_END);

  // Current state decodes
  wire in_idle = (state_q == ssp_pkg::SSP_IDLE);
  wire in_data = (state_q == ssp_pkg::SSP_DATA);

  // Start length clamped to 8..64, zero means the default
  wire [6:0] start_len = (start_s2_q == 7'h00) ? `SSP_START_DEF :
    (start_s2_q < 7'(`SSP_START_MIN)) ? 7'(`SSP_START_MIN) :
    (start_s2_q > 7'(`SSP_START_MAX)) ? 7'(`SSP_START_MAX) : start_s2_q;

  // Frame image, left aligned, per variant; unused tail bits are zero
  wire [`SSP_SHIFT_W-1:0] img_multi = {position.turns, position.angle, 2'b00};
  wire [`SSP_SHIFT_W-1:0] img_single = {position.angle, 18'h00000};
  wire [`SSP_SHIFT_W-1:0] img_ext =
    {position.turns, position.angle, 1'b0, position.healthy};

  // Variant selection; code 3 falls back to the multiturn layout
  wire sel_single = (var_s2_q == `SSP_VAR_SINGLE);
  wire sel_ext = (var_s2_q == `SSP_VAR_EXT);
  wire [`SSP_SHIFT_W-1:0] image = sel_single ? img_single :
    sel_ext ? img_ext : img_multi;
  wire [5:0] data_len = sel_single ? 6'd17 :
    sel_ext ? 6'd35 : 6'd33;
  wire bits_done = (bits_q == data_len);

  // Idle timer next value: restart on any edge, hold once expired
  assign idle_d = (fall | rise) ? 9'h000 :
    timeout ? idle_q : idle_q + 9'h001;

  // Counter next values: cleared in idle, counted on rising edges
  assign cnt_d = in_idle ? 7'h00 :
    (rise && !in_data) ? cnt_q + 7'h01 : cnt_q;
  assign bits_d = in_idle ? 6'h00 :
    (rise && in_data && !bits_done) ? bits_q + 6'h01 : bits_q;

  // Shift next value: image taken at the first falling edge of a frame
  assign shift_d = (in_idle && fall) ? image :
    (in_data && rise) ? {shift_q[`SSP_SHIFT_W-2:0], 1'b0} : shift_q;

  // Next state decodes for the data line
  wire next_idle = (state_d == ssp_pkg::SSP_IDLE);
  wire next_start = (state_d == ssp_pkg::SSP_START);
  wire next_data = (state_d == ssp_pkg::SSP_DATA);

  // First data bit is the image MSB; later ones follow the shift path
  wire first_bit = shift_q[`SSP_SHIFT_W-1];
  wire later_bit = bits_done ? 1'b0 : shift_q[`SSP_SHIFT_W-2];

  // Data line: high idle, low in start phase, MSB first in data phase
  assign data_d = next_idle ? 1'b1 :
    (rise && next_start) ? 1'b0 :
    (rise && next_data) ? (in_data ? later_bit : first_bit) : data_q;

  // Synchroniser for the master clock; the device only ever reads it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      clk_s3_q <= 1'b1;
    end
    else
    begin
      clk_s1_q <= master_clock_line;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  // Synchroniser for the start length and variant pins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_s1_q <= 7'h00;
      start_s2_q <= 7'h00;
      var_s1_q <= `SSP_VAR_MULTI;
      var_s2_q <= `SSP_VAR_MULTI;
    end
    else
    begin
      start_s1_q <= start_bits;
      start_s2_q <= start_s1_q;
      var_s1_q <= variant;
      var_s2_q <= var_s1_q;
    end
  end

  // Frame sequencing; an expired timer ends any frame unless a falling edge is seen in the same cycle
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ssp_pkg::SSP_IDLE:
      begin
        if (fall)
          state_d = ssp_pkg::SSP_ARMED;
      end
      ssp_pkg::SSP_ARMED:
      begin
        if (rise)
          state_d = ssp_pkg::SSP_START;
      end
      ssp_pkg::SSP_START:
      begin
        if (rise && cnt_q == start_len)
          state_d = ssp_pkg::SSP_DATA;
      end
      ssp_pkg::SSP_DATA:
      begin
        state_d = ssp_pkg::SSP_DATA;
      end
      default:
      begin
        state_d = ssp_pkg::SSP_IDLE;
      end
    endcase
    if (timeout && !fall && !in_idle)
      state_d = ssp_pkg::SSP_IDLE;
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= ssp_pkg::SSP_IDLE;
    else
      state_q <= state_d;
  end

  // Idle timer register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      idle_q <= 9'h000;
    else
      idle_q <= idle_d;
  end

  // Start-phase counter and data bit counter registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 7'h00;
      bits_q <= 6'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      bits_q <= bits_d;
    end
  end

  // Shift path register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      shift_q <= '0;
    else
      shift_q <= shift_d;
  end

  // Data line register; idles high so a fresh reset looks like no frame
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      data_q <= 1'b1;
    else
      data_q <= data_d;
  end

  // The pin comes straight from the data register
  assign data_out = data_q;
endmodule

/* ssp_monitor.sv */
// Checker of slave data timing and frame bits.
// Sees top ports only; samples the master clock on clk.
`timescale 1ns/1ps
module ssp_monitor (
  input clk,
  input resetn,
  input master_clock_line,
  input ssp_pkg::ssp_pos_t position,
  input [6:0] start_bits,
  input [1:0] variant,
  input data_out
);
  logic [2:0] s_q;
  logic [8:0] rc_q;
  logic [7:0] bc_q;
  ssp_pkg::ssp_pos_t p_q;
  int k;
  // Edges, cycles since rise, rise count in frame, image at frame start
  wire rise = s_q[1] & ~s_q[2], go = s_q[2] & ~s_q[1] & rc_q > 9'h11a;
  wire [8:0] rc_d = rise ? 9'h0 : rc_q + {8'h0, rc_q != 9'h1ff};
  wire [7:0] bc_d = go ? 8'h0 : bc_q + {7'h0, rise};
  wire [6:0] sl = start_bits < 7'h8 ? 7'h8 : start_bits > 7'h40 ? 7'h40 : start_bits;
  wire [34:0] w = variant == 2'h1 ? {p_q.angle, 18'h0} : {p_q[33:1], 1'b0, p_q.healthy};
  wire u = rc_q == 9'h4, t = u && k > 0, m = variant != 2'h1, b = data_out == w[35 - k];
  wire win = rise || rc_q < 9'h4 || rc_q > 9'h10a;
  assign k = bc_q - sl;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) {s_q, rc_q, bc_q, p_q} <= {3'h7, 9'h1ff, 8'h0, 34'h0};
    else {s_q, rc_q, bc_q, p_q} <= {s_q[1:0], master_clock_line, rc_d, bc_d, go ? position : p_q};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Idle level, moments of change, then each field in its bit slot
  chk_reset_idle: assert property ($rose(resetn) |-> data_out) else $error("r");
  chk_change_edge: assert property ($changed(data_out) |-> win) else $error("e");
  chk_idle_high: assert property (rc_q > 9'h118 |-> data_out) else $error("i");
  chk_start_low: assert property (u && k <= 0 |-> !data_out) else $error("s");
  chk_turn_bits: assert property (t && m && k < 17 |-> b) else $error("t");
  chk_angle_bits: assert property (t && k < 34 && (k > 16 || !m) |-> b) else $error("a");
  chk_ext_tail: assert property (t && variant == 2'h2 && k > 33 && k < 36 |-> b) else $error("x");
  chk_past_zero: assert property (t && (k > 35 || (k > 33 && variant != 2'h2)) |-> !data_out) else $error("z");
endmodule
bind ssp_slave ssp_monitor ssp_monitor_inst (.*);

/* ssp_master_model.sv */
// Master model: nclk periods of 200 ns per start, then idle high.
`timescale 1ns/1ps
module ssp_master_model (
  input start,
  input [7:0] nclk,
  input data_out,
  output logic master_clock_line = 1'b1,
  output logic [127:0] got,
  output logic done = 1'b0
);
  // Low 50 ns, high 150 ns; each bit taken as the clock would fall
  always @(posedge start)
  begin
    got = '0;
    repeat (nclk)
    begin
      #7 master_clock_line = 1'b0;
      #50 master_clock_line = 1'b1;
      #143 got = {got[126:0], data_out};
    end
    #8000 done = 1'b1;
    #25 done = 1'b0;
  end
endmodule

/* testbench.sv */
// Bench: a frame per variant and start length, and one abort.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0, master_clock_line, data_out, done;
  logic [1:0] variant = 2'h0;
  logic [6:0] start_bits = 7'h0;
  logic [7:0] nclk = 8'h0;
  logic [127:0] got, e, exp_q[$];
  ssp_pkg::ssp_pos_t position = '0;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  ssp_slave ssp_slave_inst (.*);
  ssp_master_model ssp_master_model_inst (.*);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 30000) final_report(1'b1);
  // Compare each sampled frame with the oldest note
  always @(posedge done)
  begin
    e = exp_q.pop_front();
    `CHK(got, e)
  end
  task final_report(input bit to);
    error_cnt += to;
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One frame: note expected bits, start, change position mid-frame
  task automatic frame(input logic [1:0] v, input logic [6:0] sb, input int ab);
    int sl, n, ln;
    logic [127:0] x;
    logic [34:0] w;
    repeat (4) @(negedge clk);
    {position, variant, start_bits} = {34'({$urandom, $urandom}), v, sb};
    sl = sb < 7'h8 ? 8 : sb > 7'h40 ? 64 : sb;
    ln = v == 2'h1 ? 17 : v == 2'h2 ? 35 : 33;
    w = v == 2'h1 ? {position.angle, 18'h0} : {position[33:1], 1'b0, position.healthy};
    n = ab ? ab : sl + ln + 2;
    x = '0;
    for (int j = 1; j <= n; j++) x = {x[126:0], j > sl && j <= sl + ln && w[35 + sl - j]};
    exp_q.push_back(x);
    {nclk, start} = {n[7:0], 1'b1};
    repeat (40) @(negedge clk);
    {position, start} = {34'($urandom), 1'b0};
    @(posedge done);
    repeat (1700) @(negedge clk);
  endtask
  initial
  begin
    void'($urandom(32'h650e5d9c));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    frame(2'h0, 7'h0, 0);
    frame(2'h1, 7'h40, 0);
    frame(2'h2, 7'h14, 0);
    frame(2'h3, 7'h3, 0);
    frame(2'h2, 7'h8, 12);
    frame(2'h2, 7'h7f, 0);
    final_report(1'b0);
  end
endmodule
